/* File: core/ocp_cfg_bank.v */
// configuration object bank of a two-channel overcurrent protection terminal
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - magic word write restores delivery values of nominal, button lock and fallback settings
// - per channel 8-bit nominal fuse current
// - button lock value 0 refuses front-button current changes
// - bus error drives fallback level if enabled
// - fallback level bit: 0 off, 1 on
// - request write starts command execution
// - status 255 while busy, 0 when done
// - read-only six-byte reply of last command
// - voltage calibration offset and gain per channel
// - current calibration offset and gain per channel
// - default nominal loaded at delivery and restore
// - adjustable flag and maximum nominal per channel
`include "ocp_cfg_defines.vh"
module ocp_cfg_bank (
  input wire clk,
  input wire rstn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire bus_error,
  input wire [1:0] ch_switch_cmd,
  input wire [1:0] button_req,
  input wire [15:0] button_value,
  output reg [1:0] ch_output,
  output reg [15:0] nominal_fuse_current_out,
  output reg [1:0] button_refused
);

  reg bus_error_s1;
  reg bus_error_s2;
  reg [1:0] button_req_s1;
  reg [1:0] button_req_s2;
  reg [1:0] button_req_d;
  reg [15:0] button_value_s1;
  reg [15:0] button_value_s2;
  reg [1:0] ch_switch_s1;
  reg [1:0] ch_switch_s2;
  reg [31:0] restore_trigger_reg;
  reg [15:0] command_request_reg;
  reg [7:0] command_progress_reg;
  reg [47:0] command_reply_reg;
  reg [3:0] cmd_timer_reg;
  reg [7:0] nominal_reg [0:1];
  reg [7:0] button_lock_reg [0:1];
  reg fallback_en_reg [0:1];
  reg fallback_lvl_reg [0:1];
  reg [15:0] voff_reg [0:1];
  reg [15:0] vgain_reg [0:1];
  reg [15:0] ioff_reg [0:1];
  reg [15:0] igain_reg [0:1];
  reg [15:0] defnom_reg [0:1];
  reg [15:0] limit_reg [0:1];
  reg [15:0] adjust_reg [0:1];
  reg ack_reg;
  reg [31:0] rdata_next;

  wire req = avs_read | avs_write;
  // a write lands at the edge where waitrequest is seen low
  wire wr_take = avs_write & ack_reg;
  wire rd_take = avs_read & ~ack_reg;
  wire ch_sel = avs_address[5];
  wire [3:0] ch_off = avs_address[3:0];
  // channel blocks at 0x10 and 0x20
  wire in_ch = (avs_address[7:6] == 2'b00) & (avs_address[5] ^ avs_address[4]);
  wire restore_hit = wr_take & (avs_address == `A_RESTORE) & (avs_writedata == `RESTORE_MAGIC);

  // byte-lane merge of a 16-bit field
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // nominal write allowed only when adjustable and within limit
  function nom_ok;
    input [15:0] val;
    input [15:0] lim;
    input [15:0] adj;
    begin
      nom_ok = (adj != 16'h0000) && (val <= lim) && (val[15:8] == 8'h00);
    end
  endfunction

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_error_s1 <= 1'b0;
      bus_error_s2 <= 1'b0;
      button_req_s1 <= 2'b00;
      button_req_s2 <= 2'b00;
      button_req_d <= 2'b00;
      button_value_s1 <= 16'h0000;
      button_value_s2 <= 16'h0000;
      ch_switch_s1 <= 2'b00;
      ch_switch_s2 <= 2'b00;
    end
    else
    begin
      bus_error_s1 <= bus_error;
      bus_error_s2 <= bus_error_s1;
      button_req_s1 <= button_req;
      button_req_s2 <= button_req_s1;
      button_req_d <= button_req_s2;
      button_value_s1 <= button_value;
      button_value_s2 <= button_value_s1;
      ch_switch_s1 <= ch_switch_cmd;
      ch_switch_s2 <= ch_switch_s1;
    end
  end

  // bus slave: waitrequest low one cycle after a request is seen
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      avs_waitrequest <= ~(req & ~ack_reg);
      if (rd_take)
        avs_readdata <= rdata_next;
    end
  end

  always @*
  begin
    rdata_next = 32'h00000000;
    if (in_ch)
    begin
      case (ch_off)
        `O_SET_CNT: rdata_next = {24'h000000, `CNT_SETTINGS};
        `O_NOMINAL: rdata_next = {24'h000000, nominal_reg[ch_sel]};
        `O_BUTTON: rdata_next = {24'h000000, button_lock_reg[ch_sel]};
        `O_SAFE_CNT: rdata_next = {24'h000000, `CNT_SAFE};
        `O_SAFE_EN: rdata_next = {31'h00000000, fallback_en_reg[ch_sel]};
        `O_SAFEV_CNT: rdata_next = {24'h000000, `CNT_SAFE};
        `O_SAFE_LVL: rdata_next = {31'h00000000, fallback_lvl_reg[ch_sel]};
        `O_VEND_CNT: rdata_next = {24'h000000, `CNT_VENDOR};
        `O_VOFF: rdata_next = {16'h0000, voff_reg[ch_sel]};
        `O_VGAIN: rdata_next = {16'h0000, vgain_reg[ch_sel]};
        `O_IOFF: rdata_next = {16'h0000, ioff_reg[ch_sel]};
        `O_IGAIN: rdata_next = {16'h0000, igain_reg[ch_sel]};
        `O_DEFNOM: rdata_next = {16'h0000, defnom_reg[ch_sel]};
        `O_LIMIT: rdata_next = {16'h0000, limit_reg[ch_sel]};
        `O_ADJUST: rdata_next = {16'h0000, adjust_reg[ch_sel]};
        `O_BUTTON_STAT: rdata_next = {31'h00000000, button_refused[ch_sel]};
        default: rdata_next = 32'h00000000;
      endcase
    end
    else
    begin
      case (avs_address)
        `A_RESTORE_CNT: rdata_next = {24'h000000, `CNT_RESTORE};
        `A_RESTORE: rdata_next = restore_trigger_reg;
        `A_CMD_CNT: rdata_next = {24'h000000, `CNT_COMMAND};
        `A_CMD_REQ: rdata_next = {16'h0000, command_request_reg};
        `A_CMD_STATUS: rdata_next = {24'h000000, command_progress_reg};
        `A_CMD_REPLY_LO: rdata_next = command_reply_reg[31:0];
        `A_CMD_REPLY_HI: rdata_next = {16'h0000, command_reply_reg[47:32]};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // global objects and command mailbox
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      restore_trigger_reg <= 32'h00000000;
      command_request_reg <= 16'h0000;
      command_progress_reg <= `STATUS_DONE;
      command_reply_reg <= 48'h000000000000;
      cmd_timer_reg <= 4'h0;
    end
    else
    begin
      if (wr_take && avs_address == `A_RESTORE)
        restore_trigger_reg <= avs_writedata;
      if (wr_take && avs_address == `A_CMD_REQ)
      begin
        command_request_reg <= merge16(command_request_reg, avs_writedata, avs_byteenable);
        command_progress_reg <= `STATUS_BUSY;
        cmd_timer_reg <= `CMD_EXEC_CYCLES;
      end
      else if (command_progress_reg == `STATUS_BUSY)
      begin
        if (cmd_timer_reg == 4'h1)
        begin
          command_progress_reg <= `STATUS_DONE;
          command_reply_reg <= {32'h00000000, command_request_reg};
        end
        cmd_timer_reg <= cmd_timer_reg - 4'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      wire wsel = wr_take & in_ch & (ch_sel == g);
      wire btn_edge = button_req_s2[g] & ~button_req_d[g];
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          nominal_reg[g] <= `DEF_NOMINAL_FUSE;
          button_lock_reg[g] <= 8'h00;
          fallback_en_reg[g] <= `FALLBACK_EN_RST;
          fallback_lvl_reg[g] <= `FALLBACK_LVL_RST;
          voff_reg[g] <= `CAL_OFFS_RST;
          vgain_reg[g] <= `CAL_GAIN_RST;
          ioff_reg[g] <= `CAL_OFFS_RST;
          igain_reg[g] <= `CAL_GAIN_RST;
          defnom_reg[g] <= `DEF_NOMINAL;
          limit_reg[g] <= `DEF_LIMIT;
          adjust_reg[g] <= `DEF_ADJUST;
          button_refused[g] <= 1'b0;
          ch_output[g] <= 1'b0;
        end
        else
        begin
          if (restore_hit)
          begin
            nominal_reg[g] <= defnom_reg[g][7:0];
            button_lock_reg[g] <= 8'h00;
            fallback_en_reg[g] <= `FALLBACK_EN_RST;
            fallback_lvl_reg[g] <= `FALLBACK_LVL_RST;
          end
          else if (wsel)
          begin
            case (ch_off)
              `O_NOMINAL:
                if (avs_byteenable[0] && nom_ok({8'h00, avs_writedata[7:0]}, limit_reg[g],
                    adjust_reg[g]))
                  nominal_reg[g] <= avs_writedata[7:0];
              `O_BUTTON: if (avs_byteenable[0]) button_lock_reg[g] <= avs_writedata[7:0];
              `O_SAFE_EN: if (avs_byteenable[0]) fallback_en_reg[g] <= avs_writedata[0];
              `O_SAFE_LVL: if (avs_byteenable[0]) fallback_lvl_reg[g] <= avs_writedata[0];
              `O_VOFF: voff_reg[g] <= merge16(voff_reg[g], avs_writedata, avs_byteenable);
              `O_VGAIN: vgain_reg[g] <= merge16(vgain_reg[g], avs_writedata, avs_byteenable);
              `O_IOFF: ioff_reg[g] <= merge16(ioff_reg[g], avs_writedata, avs_byteenable);
              `O_IGAIN: igain_reg[g] <= merge16(igain_reg[g], avs_writedata, avs_byteenable);
              `O_DEFNOM: defnom_reg[g] <= merge16(defnom_reg[g], avs_writedata, avs_byteenable);
              `O_LIMIT: limit_reg[g] <= merge16(limit_reg[g], avs_writedata, avs_byteenable);
              `O_ADJUST: adjust_reg[g] <= merge16(adjust_reg[g], avs_writedata, avs_byteenable);
              default: button_refused[g] <= button_refused[g];
            endcase
          end
          else if (btn_edge)
          begin
            if (button_lock_reg[g] == 8'h00)
              button_refused[g] <= 1'b1;
            else if (nom_ok(button_value_s2, limit_reg[g], adjust_reg[g]))
            begin
              nominal_reg[g] <= button_value_s2[7:0];
              button_refused[g] <= 1'b0;
            end
            else
              button_refused[g] <= 1'b1;
          end
          if (bus_error_s2)
          begin
            if (fallback_en_reg[g])
              ch_output[g] <= fallback_lvl_reg[g];
          end
          else
            ch_output[g] <= ch_switch_s2[g];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      nominal_fuse_current_out <= 16'h0000;
    else
      nominal_fuse_current_out <= {nominal_reg[1], nominal_reg[0]};
  end

endmodule // ocp_cfg_bank
`default_nettype wire

/* File: core/ocp_cfg_defines.vh */
// register offsets, field values and reset values of the configuration bank
`ifndef OCP_CFG_DEFINES_VH
`define OCP_CFG_DEFINES_VH
`define RESTORE_MAGIC 32'h64616f6c
`define CNT_RESTORE 8'h01
`define CNT_SETTINGS 8'h19
`define CNT_SAFE 8'h01
`define CNT_COMMAND 8'h03
`define CNT_VENDOR 8'h19
`define CAL_GAIN_RST 16'h4000
`define CAL_OFFS_RST 16'h0000
`define FALLBACK_EN_RST 1'b1
`define FALLBACK_LVL_RST 1'b0
`define STATUS_BUSY 8'hff
`define STATUS_DONE 8'h00
`define DEF_NOMINAL 16'h0004
`define DEF_NOMINAL_FUSE 8'h04
`define DEF_LIMIT 16'h000a
`define DEF_ADJUST 16'h0001
`define CMD_EXEC_CYCLES 4'h8
// word addresses; channel block base = 8'h10 * (ch + 1)
`define A_RESTORE_CNT 8'h00
`define A_RESTORE 8'h01
`define A_CMD_CNT 8'h02
`define A_CMD_REQ 8'h03
`define A_CMD_STATUS 8'h04
`define A_CMD_REPLY_LO 8'h05
`define A_CMD_REPLY_HI 8'h06
`define A_CH_BASE 8'h10
`define O_SET_CNT 4'h0
`define O_NOMINAL 4'h1
`define O_BUTTON 4'h2
`define O_SAFE_CNT 4'h3
`define O_SAFE_EN 4'h4
`define O_SAFEV_CNT 4'h5
`define O_SAFE_LVL 4'h6
`define O_VEND_CNT 4'h7
`define O_VOFF 4'h8
`define O_VGAIN 4'h9
`define O_IOFF 4'ha
`define O_IGAIN 4'hb
`define O_DEFNOM 4'hc
`define O_LIMIT 4'hd
`define O_ADJUST 4'he
`define O_BUTTON_STAT 4'hf
`endif

/* File: test/cfg_master.sv */
// fieldbus-side master model on the register bus
`timescale 1ns/1ps
`default_nettype none
module cfg_master (
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output var logic [7:0] avs_address,
  output var logic avs_read,
  output var logic avs_write,
  output var logic [31:0] avs_writedata
);
  initial
  begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= w ? d : ~avs_writedata;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest)
      tb_top.hang();
  endtask
endmodule // cfg_master
`default_nettype wire

/* File: test/ocp_cfg_checker.sv */
// assertion checker for the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module ocp_cfg_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bus_error,
  input wire logic [1:0] ch_switch_cmd,
  input wire logic [1:0] button_req,
  input wire logic [1:0] ch_output,
  input wire logic [15:0] nominal_fuse_current_out
);
  logic [1:0] wait_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  always @(posedge clk or negedge rstn)
    if (!rstn)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= ((avs_read || avs_write) && avs_waitrequest) ? wait_cnt + 2'h1 : 2'h0;
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  AST_WAIT_CNT: assert property (wait_cnt < 2'h2)
    else $error("request waited too long");
  AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood more than one cycle");
  AST_CAUSE: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("answer without request");
  AST_RDATA: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
  AST_NOM_RESET: assert property (!$past(rstn) |=> nominal_fuse_current_out == 16'h0404)
    else $error("nominal not loaded from default after reset");
  AST_NOM_QUIET: assert property ((!avs_write && $stable(button_req)) [*6]
    |=> $stable(nominal_fuse_current_out))
    else $error("nominal changed without a cause");
  AST_FOLLOW: assert property ((!bus_error && $stable(ch_switch_cmd)) [*5]
    |-> ch_output == ch_switch_cmd)
    else $error("output does not follow switch command");
  AST_HOLD: assert property ((bus_error && !avs_write) [*6] |=> $stable(ch_output))
    else $error("output moved during bus error");
  COV_WR: cover property (avs_write && !avs_waitrequest);
  COV_RD: cover property (avs_read && !avs_waitrequest);
  COV_ERR: cover property ($rose(bus_error));
endmodule // ocp_cfg_checker
bind ocp_cfg_bank ocp_cfg_checker chk (.clk(clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .bus_error(bus_error), .ch_switch_cmd(ch_switch_cmd), .button_req(button_req),
  .ch_output(ch_output), .nominal_fuse_current_out(nominal_fuse_current_out));
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] RST_TAB [15] = '{16'h19, 16'h4, 16'h0, 16'h1, 16'h1, 16'h1, 16'h0,
    16'h19, 16'h0, 16'h4000, 16'h0, 16'h4000, 16'h4, 16'ha, 16'h1};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_error = 1'b0;
  logic [1:0] ch_switch_cmd = 2'h0;
  logic [1:0] button_req = 2'h0;
  logic [15:0] button_value = 16'h0;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] ch_output;
  logic [1:0] button_refused;
  logic [15:0] nom;
  logic [31:0] q;
  int err_count = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  ocp_cfg_bank uut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_error(bus_error),
    .ch_switch_cmd(ch_switch_cmd), .button_req(button_req), .button_value(button_value),
    .ch_output(ch_output), .nominal_fuse_current_out(nom), .button_refused(button_refused));
  cfg_master mst (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst.xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    mst.xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task hang;
    err_count++;
    summarize();
  endtask
  task automatic test_reset;
    repeat (2) @(posedge clk);
    chk({16'h0, nom}, 32'h0404);
    for (int c = 1; c < 3; c++)
      for (int o = 0; o < 15; o++)
        if (o != 2)
          rdc({c[3:0], o[3:0]}, {16'h0, RST_TAB[o]});
    rdc(8'h00, 32'h1);
    rdc(8'h02, 32'h3);
    rdc(8'h04, 32'h0);
    rdc(8'h07, 32'h0);
    wr(8'h00, 32'hff);
    rdc(8'h00, 32'h1);
  endtask
  task automatic test_nominal;
    wr(8'h11, 32'h7);
    rdc(8'h11, 32'h7);
    chk({24'h0, nom[7:0]}, 32'h7);
    wr(8'h11, 32'hb);
    rdc(8'h11, 32'h7);
    wr(8'h11, 32'ha);
    rdc(8'h11, 32'ha);
    wr(8'h1e, 32'h0);
    wr(8'h11, 32'h5);
    rdc(8'h11, 32'ha);
    wr(8'h1e, 32'h1);
  endtask
  task automatic test_command;
    int n;
    wr(8'h03, 32'h1234);
    rdc(8'h04, 32'hff);
    n = 0;
    do
    begin
      mst.xfer(8'h04, 1'b0, 32'h0, q);
      n++;
    end while (q === 32'hff && n < 20);
    chk(q, 32'h0);
    rdc(8'h05, 32'h1234);
    rdc(8'h06, 32'h0);
  endtask
  task automatic test_fallback;
    wr(8'h16, 32'h1);
    wr(8'h24, 32'h0);
    ch_switch_cmd <= 2'h2;
    repeat (6) @(posedge clk);
    chk({30'h0, ch_output}, 32'h2);
    bus_error <= 1'b1;
    ch_switch_cmd <= 2'h0;
    repeat (6) @(posedge clk);
    chk({30'h0, ch_output}, 32'h3);
    wr(8'h16, 32'h0);
    repeat (4) @(posedge clk);
    chk({30'h0, ch_output}, 32'h2);
    bus_error <= 1'b0;
    repeat (6) @(posedge clk);
    chk({30'h0, ch_output}, 32'h0);
  endtask
  task automatic test_restore;
    wr(8'h01, 32'h64616f6d);
    rdc(8'h11, 32'ha);
    wr(8'h01, 32'h64616f6c);
    rdc(8'h11, 32'h4);
    rdc(8'h24, 32'h1);
    chk({16'h0, nom}, 32'h0404);
  endtask
  task automatic test_button;
    wr(8'h12, 32'h0);
    button_value <= 16'h6;
    button_req <= 2'h1;
    repeat (8) @(posedge clk);
    chk({16'h0, nom}, 32'h0404);
    chk({30'h0, button_refused}, 32'h1);
    button_req <= 2'h0;
    wr(8'h12, 32'h1);
    button_req <= 2'h1;
    repeat (8) @(posedge clk);
    chk({16'h0, nom}, 32'h0406);
    chk({30'h0, button_refused}, 32'h0);
    button_req <= 2'h0;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_nominal();
    test_command();
    test_fallback();
    test_restore();
    test_button();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
